// file: include/pws_map.vh
`ifndef PWS_MAP_VH
`define PWS_MAP_VH

// device command codes
`define PWS_CMD_READ_ARRAY 8'hFF
`define PWS_CMD_READ_STATUS 8'h70
`define PWS_CMD_CLEAR_STATUS 8'h50
`define PWS_CMD_SUSPEND 8'hB0
`define PWS_CMD_CONFIRM 8'hD0
`define PWS_CMD_BUF_WRITE 8'hE8
`define PWS_CMD_BUF_WRITE_BA 8'hEA
`define PWS_CMD_ERASE_SETUP 8'h20
`define PWS_CMD_PROGRAM 8'h40

// device status bit positions
`define PWS_SR_READY 7
`define PWS_SR_ERASE_SUSP 6
`define PWS_SR_ERASE_FAIL 5
`define PWS_SR_WRITE_FAIL 4
`define PWS_SR_SUPPLY_ERR 3
`define PWS_SR_WRITE_SUSP 2
`define PWS_SR_LOCKED 1

// controller register offsets
`define PWS_REG_CTRL 4'h0
`define PWS_REG_ADDR 4'h1
`define PWS_REG_DATA 4'h2
`define PWS_REG_COUNT 4'h3
`define PWS_REG_STATUS 4'h4
`define PWS_REG_RDATA 4'h5
`define PWS_REG_BUFWR 4'h6

// control register op codes, bits 3:0 of a write to CTRL starts one
`define PWS_OP_BUF_WRITE 4'h1
`define PWS_OP_ERASE 4'h2
`define PWS_OP_SUSPEND 4'h3
`define PWS_OP_RESUME 4'h4
`define PWS_OP_READ_ARRAY 4'h5
`define PWS_OP_CLEAR 4'h6
`define PWS_OP_READ 4'h7
`define PWS_OP_PROGRAM 4'h8
`define PWS_CTRL_BITALT 4

// bus timer reloads (a phase lasts one cycle more than its value), buffer depth in words, status reset value
`define PWS_T_PULSE 4'h8
`define PWS_T_GAP 4'h3
`define PWS_BUF_WORDS 32
`define PWS_RST_CTRL 8'h00

`endif

// file: design/pws_buf_mem.v
`timescale 1ns/1ps
module pws_buf_mem #(
   parameter DW = 16,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk, // clock
   input wire clk_en, // clock enable
   input wire wr_en, // write strobe
   input wire [AW-1:0] wr_addr, // write index
   input wire [DW-1:0] wr_data, // write word
   input wire [AW-1:0] rd_addr, // read index
   output reg [DW-1:0] rd_data_q // registered read word
);
   reg [DW-1:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data_q <= mem[rd_addr];
      end
   end
endmodule

// file: design/pws_host.v
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "pws_map.vh"
module pws_host #(
   parameter AW = 23,
   parameter DW = 16,
   parameter BLK_LSB = 16
) (
   input wire clk, // 100 MHz clock
   input wire rst_b, // async reset, active low
   input wire clk_en, // freezes all state when low
   input wire [3:0] reg_addr, // register index
   input wire [31:0] reg_wdata, // register write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [31:0] reg_rdata_q, // read data, cycle after strobe
   output reg [AW-1:0] mem_addr_q, // device address
   input wire [DW-1:0] mem_dq_in, // device data pins, in
   output reg [DW-1:0] mem_dq_out_q, // device data pins, out
   output reg mem_dq_oe_q, // high while driving data
   output reg mem_ce_n_q, // chip enable, active low
   output reg mem_oe_n_q, // output enable, active low
   output reg mem_we_n_q // write enable, active low
);
   localparam ST_IDLE = 4'h0;
   localparam ST_WRITE = 4'h1;
   localparam ST_READ = 4'h2;
   localparam ST_GAP = 4'h3;
   localparam ST_NEXT = 4'h4;

   // bus step kinds held in the sequence table
   localparam K_CMD = 3'h0;
   localparam K_CNT = 3'h1;
   localparam K_DATA = 3'h2;
   localparam K_POLL = 3'h3;
   localparam K_READ = 3'h4;
   localparam K_DONE = 3'h5;

   reg [3:0] st_q;
   reg [3:0] tmr_q;
   reg [3:0] op_q;
   reg [2:0] step_q;
   reg bitalt_q;
   reg busy_q;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] data_q;
   reg [4:0] count_q;
   reg [4:0] widx_q;
   reg [4:0] wptr_q;
   reg [7:0] sr_q;
   reg [DW-1:0] rword_q;
   reg abort_q;
   reg susp_req_q;
   reg [DW-1:0] dq_s1_q;
   reg [DW-1:0] dq_s2_q;

   wire [DW-1:0] buf_word;
   reg [2:0] kind;
   reg [7:0] cmd;
   reg [AW-1:0] step_addr;

   pws_buf_mem #(.DW(DW), .DEPTH(`PWS_BUF_WORDS), .AW(5)) u_buf (
      .clk(clk),
      .clk_en(clk_en),
      .wr_en(reg_wr && reg_addr == `PWS_REG_BUFWR && !busy_q),
      .wr_addr(wptr_q),
      .wr_data(reg_wdata[DW-1:0]),
      .rd_addr(widx_q),
      .rd_data_q(buf_word)
   );

   // per-op sequence table: each op is a short list of bus steps
   always @* begin
      kind = K_DONE;
      cmd = `PWS_CMD_READ_ARRAY;
      step_addr = addr_q;
      case (op_q)
         `PWS_OP_BUF_WRITE: begin
            case (step_q)
               3'h0: begin
                  kind = K_CMD;
                  cmd = bitalt_q ? `PWS_CMD_BUF_WRITE_BA : `PWS_CMD_BUF_WRITE;
               end
               3'h1: kind = K_CNT;
               3'h2: kind = K_DATA;
               3'h3: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_CONFIRM;
               end
               3'h4: kind = K_POLL;
               default: kind = K_DONE;
            endcase
         end
         `PWS_OP_ERASE: begin
            case (step_q)
               3'h0: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_ERASE_SETUP;
               end
               3'h1: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_CONFIRM;
               end
               3'h2: kind = K_POLL;
               default: kind = K_DONE;
            endcase
         end
         `PWS_OP_SUSPEND: begin
            case (step_q)
               3'h0: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_READ_STATUS;
               end
               3'h1: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_SUSPEND;
               end
               3'h2: kind = K_POLL;
               default: kind = K_DONE;
            endcase
         end
         `PWS_OP_RESUME: begin
            if (step_q == 3'h0) begin
               kind = K_CMD;
               cmd = `PWS_CMD_CONFIRM;
            end
         end
         `PWS_OP_READ_ARRAY: begin
            if (step_q == 3'h0) begin
               kind = K_CMD;
               cmd = `PWS_CMD_READ_ARRAY;
            end
         end
         `PWS_OP_CLEAR: begin
            if (step_q == 3'h0) begin
               kind = K_CMD;
               cmd = `PWS_CMD_CLEAR_STATUS;
            end
         end
         `PWS_OP_READ: begin
            if (step_q == 3'h0) begin
               kind = K_READ;
            end
         end
         `PWS_OP_PROGRAM: begin
            case (step_q)
               3'h0: begin
                  kind = K_CMD;
                  cmd = `PWS_CMD_PROGRAM;
               end
               3'h1: kind = K_DATA;
               3'h2: kind = K_POLL;
               default: kind = K_DONE;
            endcase
         end
         default: kind = K_DONE;
      endcase
      // data words of a buffer walk up from the start address
      if (kind == K_DATA && op_q == `PWS_OP_BUF_WRITE) begin
         step_addr = addr_q + {{(AW-5){1'b0}}, widx_q};
      end
   end

   // a buffer that would cross out of the start block is caught before it starts
   wire [AW-1:0] last_addr = addr_q + {{(AW-5){1'b0}}, count_q};
   wire cross_blk = (last_addr[AW-1:BLK_LSB] != addr_q[AW-1:BLK_LSB]);

   wire ctrl_go = reg_wr && reg_addr == `PWS_REG_CTRL && !busy_q;
   // the only order taken while busy: a suspend of the running write or erase
   wire susp_go = reg_wr && reg_addr == `PWS_REG_CTRL && busy_q &&
      reg_wdata[3:0] == `PWS_OP_SUSPEND;
   wire err_any = sr_q[`PWS_SR_LOCKED] | sr_q[`PWS_SR_SUPPLY_ERR] |
      sr_q[`PWS_SR_WRITE_FAIL] | sr_q[`PWS_SR_ERASE_FAIL];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         tmr_q <= 4'h0;
         op_q <= 4'h0;
         step_q <= 3'h0;
         bitalt_q <= 1'b0;
         busy_q <= 1'b0;
         addr_q <= {AW{1'b0}};
         data_q <= {DW{1'b0}};
         count_q <= 5'h00;
         widx_q <= 5'h00;
         wptr_q <= 5'h00;
         sr_q <= `PWS_RST_CTRL;
         rword_q <= {DW{1'b0}};
         abort_q <= 1'b0;
         susp_req_q <= 1'b0;
         dq_s1_q <= {DW{1'b0}};
         dq_s2_q <= {DW{1'b0}};
         reg_rdata_q <= 32'h0000_0000;
         mem_addr_q <= {AW{1'b0}};
         mem_dq_out_q <= {DW{1'b0}};
         mem_dq_oe_q <= 1'b0;
         mem_ce_n_q <= 1'b1;
         mem_oe_n_q <= 1'b1;
         mem_we_n_q <= 1'b1;
      end else if (clk_en) begin
         dq_s1_q <= mem_dq_in;
         dq_s2_q <= dq_s1_q;

         reg_rdata_q <= 32'h0000_0000;
         if (reg_rd) begin
            if (reg_addr == `PWS_REG_CTRL) begin
               reg_rdata_q <= {26'h0, abort_q, busy_q, op_q};
            end else if (reg_addr == `PWS_REG_ADDR) begin
               reg_rdata_q <= {{(32-AW){1'b0}}, addr_q};
            end else if (reg_addr == `PWS_REG_DATA) begin
               reg_rdata_q <= {{(32-DW){1'b0}}, data_q};
            end else if (reg_addr == `PWS_REG_COUNT) begin
               reg_rdata_q <= {27'h0, count_q};
            end else if (reg_addr == `PWS_REG_STATUS) begin
               reg_rdata_q <= {22'h0, err_any, abort_q, sr_q};
            end else if (reg_addr == `PWS_REG_RDATA) begin
               reg_rdata_q <= {{(32-DW){1'b0}}, rword_q};
            end
         end
         if (reg_wr && !busy_q) begin
            if (reg_addr == `PWS_REG_ADDR) begin
               addr_q <= reg_wdata[AW-1:0];
            end else if (reg_addr == `PWS_REG_DATA) begin
               data_q <= reg_wdata[DW-1:0];
            end else if (reg_addr == `PWS_REG_COUNT) begin
               count_q <= reg_wdata[4:0];
               wptr_q <= 5'h00;
            end else if (reg_addr == `PWS_REG_BUFWR) begin
               wptr_q <= wptr_q + 5'h01;
            end
         end

         case (st_q)
            ST_IDLE: begin
               if (ctrl_go) begin
                  op_q <= reg_wdata[3:0];
                  bitalt_q <= reg_wdata[`PWS_CTRL_BITALT];
                  step_q <= 3'h0;
                  widx_q <= 5'h00;
                  busy_q <= 1'b1;
                  abort_q <= 1'b0;
                  susp_req_q <= 1'b0;
                  // never issue addresses outside the setup block
                  if (reg_wdata[3:0] == `PWS_OP_BUF_WRITE && cross_blk) begin
                     abort_q <= 1'b1;
                     busy_q <= 1'b0;
                  end else begin
                     st_q <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               tmr_q <= `PWS_T_PULSE;
               mem_addr_q <= step_addr;
               mem_ce_n_q <= 1'b0;
               if (kind == K_DONE) begin
                  mem_ce_n_q <= 1'b1;
                  busy_q <= 1'b0;
                  st_q <= ST_IDLE;
               end else if (kind == K_POLL || kind == K_READ) begin
                  mem_oe_n_q <= 1'b0; // fresh read cycle each poll
                  mem_dq_oe_q <= 1'b0;
                  st_q <= ST_READ;
               end else begin
                  mem_we_n_q <= 1'b0;
                  mem_dq_oe_q <= 1'b1;
                  if (kind == K_CMD) begin
                     mem_dq_out_q <= {{(DW-8){1'b0}}, cmd};
                  end else if (kind == K_CNT) begin
                     mem_dq_out_q <= {{(DW-5){1'b0}}, count_q};
                  end else if (op_q == `PWS_OP_BUF_WRITE) begin
                     mem_dq_out_q <= buf_word;
                  end else begin
                     mem_dq_out_q <= data_q;
                  end
                  st_q <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (tmr_q != 4'h0) begin
                  tmr_q <= tmr_q - 4'h1;
               end else begin
                  mem_we_n_q <= 1'b1;
                  mem_ce_n_q <= 1'b1;
                  tmr_q <= `PWS_T_GAP;
                  st_q <= ST_GAP;
                  if (kind == K_DATA && op_q == `PWS_OP_BUF_WRITE &&
                        widx_q != count_q) begin
                     widx_q <= widx_q + 5'h01;
                  end else begin
                     step_q <= step_q + 3'h1;
                  end
               end
            end
            ST_READ: begin
               if (tmr_q != 4'h0) begin
                  tmr_q <= tmr_q - 4'h1;
               end else begin
                  mem_oe_n_q <= 1'b1;
                  mem_ce_n_q <= 1'b1;
                  tmr_q <= `PWS_T_GAP;
                  st_q <= ST_GAP;
                  if (kind == K_READ) begin
                     rword_q <= dq_s2_q;
                     step_q <= step_q + 3'h1;
                  end else begin
                     // device keeps errors sticky; we mirror them
                     sr_q <= dq_s2_q[7:0];
                     if (dq_s2_q[`PWS_SR_READY]) begin
                        step_q <= step_q + 3'h1; // poll until ready
                     end else if (susp_req_q && op_q != `PWS_OP_SUSPEND) begin
                        // switch only between polls so no bus cycle is cut short
                        op_q <= `PWS_OP_SUSPEND;
                        step_q <= 3'h0;
                        susp_req_q <= 1'b0;
                     end
                  end
               end
            end
            ST_GAP: begin
               if (tmr_q != 4'h0) begin
                  tmr_q <= tmr_q - 4'h1;
               end else begin
                  st_q <= ST_NEXT;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         if (susp_go) begin
            susp_req_q <= 1'b1;
         end
      end
   end
endmodule

// file: tb/pws_host_monitor.sv
`timescale 1ns/1ps
module pws_host_monitor #(
   parameter AW = 23,
   parameter DW = 16
) (
   input wire clk, // clock
   input wire rst_b, // reset, active low
   input wire reg_rd, // read strobe
   input wire [31:0] reg_rdata_q, // read data
   input wire [AW-1:0] mem_addr_q, // device address
   input wire [DW-1:0] mem_dq_out_q, // drive data
   input wire mem_dq_oe_q, // drive enable
   input wire mem_ce_n_q, // chip enable, active low
   input wire mem_oe_n_q, // output enable, active low
   input wire mem_we_n_q // write enable, active low
);
   reg [7:0] last_cmd_q;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         last_cmd_q <= 8'h00;
      else if ($fell(mem_we_n_q))
         last_cmd_q <= mem_dq_out_q[7:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_WR_PULSE: assert property ($fell(mem_we_n_q) |-> (!mem_we_n_q && !mem_ce_n_q)[*8]
      ##1 (!mem_we_n_q && !mem_ce_n_q) ##1 mem_we_n_q) else $error("write pulse length wrong");
   AST_WR_HOLD: assert property (!mem_we_n_q && !$fell(mem_we_n_q) |->
      $stable(mem_addr_q) && $stable(mem_dq_out_q)) else $error("write pins moved");
   AST_WR_DRIVE: assert property (!mem_we_n_q |-> mem_dq_oe_q && mem_oe_n_q)
      else $error("write without driving data");
   AST_RD_FLOAT: assert property (!mem_oe_n_q |-> !mem_dq_oe_q && mem_we_n_q)
      else $error("read while driving data");
   AST_RD_PULSE: assert property ($fell(mem_oe_n_q) |-> (!mem_oe_n_q && !mem_ce_n_q)[*8]
      ##1 (!mem_oe_n_q && !mem_ce_n_q) ##1 mem_oe_n_q) else $error("read pulse length wrong");
   AST_GAP: assert property ($rose(mem_we_n_q) |-> mem_ce_n_q[*4])
      else $error("chip enable gap too short");
   AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data outside its cycle");
   AST_ERASE_PAIR: assert property ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'h20 |->
      ##[10:40] ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'hD0)) else $error("no erase confirm");
   AST_BUF_COUNT: assert property ($fell(mem_we_n_q) && mem_dq_out_q[7:1] == 7'h74 |->
      ##[10:40] ($fell(mem_we_n_q) && mem_dq_out_q <= 16'h001F)) else $error("bad word count");
   AST_SUSP_ORDER: assert property ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'hB0 |->
      last_cmd_q == 8'h70) else $error("suspend without status command");
   COV_BUF: cover property ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'hEA);
   COV_ERASE: cover property ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'h20);
   COV_SUSP: cover property ($fell(mem_we_n_q) && mem_dq_out_q[7:0] == 8'hB0);
endmodule

bind pws_host pws_host_monitor #(.AW(AW), .DW(DW)) u_mon (.clk(clk), .rst_b(rst_b),
   .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .mem_addr_q(mem_addr_q),
   .mem_dq_out_q(mem_dq_out_q), .mem_dq_oe_q(mem_dq_oe_q), .mem_ce_n_q(mem_ce_n_q),
   .mem_oe_n_q(mem_oe_n_q), .mem_we_n_q(mem_we_n_q));

// file: tb/pws_dev_model.sv
`timescale 1ns/1ps
module pws_dev_model #(
   parameter LOCK_BLK = 7'h01
) (
   input wire clk, // clock
   input wire [22:0] addr, // device address
   input wire [15:0] dq_in, // data from host
   output wire [15:0] dq_out, // data to host
   input wire ce_n, // chip enable, active low
   input wire oe_n, // output enable, active low
   input wire we_n // write enable, active low
);
   reg [7:0] sr_q = 8'h00;
   reg [15:0] arr [0:63];
   reg [15:0] last_q = 16'h0000;
   reg we_q = 1'b1;
   reg stat_q = 1'b0;
   reg ers_q = 1'b0;
   reg eop_q = 1'b0;
   reg prg_q = 1'b0;
   reg [1:0] bst_q = 2'h0;
   reg [5:0] left_q = 6'h00;
   reg [6:0] blk_q = 7'h00;
   integer busy = 0;
   wire [7:0] st = {busy == 0 || sr_q[2] || sr_q[6], sr_q[6:0]};
   wire [15:0] val = stat_q ? {8'h00, st} : arr[{addr[16], addr[4:0]}];
   // no pull-up on the data lines, so an undriven bus shows the inverse of the last word
   assign dq_out = (!ce_n && !oe_n) ? val : ~last_q;
   always @(posedge clk) begin
      we_q <= we_n;
      if (!ce_n && !oe_n)
         last_q <= val;
      if (busy > 0 && !sr_q[2] && !sr_q[6])
         busy <= busy - 1;
      if (!we_n && we_q && !ce_n) begin
         if (bst_q != 2'h0 && addr[22:16] != blk_q) begin
            bst_q <= 2'h0;
            sr_q[5:4] <= 2'h3;
         end else if (bst_q == 2'h1) begin
            left_q <= {1'b0, dq_in[4:0]} + 6'h01;
            bst_q <= 2'h2;
         end else if (bst_q == 2'h2) begin
            arr[{addr[16], addr[4:0]}] <= dq_in;
            left_q <= left_q - 6'h01;
            if (left_q == 6'h01)
               bst_q <= 2'h3;
         end else if (bst_q == 2'h3 || ers_q) begin
            bst_q <= 2'h0;
            ers_q <= 1'b0;
            if (dq_in[7:0] != 8'hD0)
               sr_q[5:4] <= 2'h3;
            else if (ers_q && addr[22:16] == LOCK_BLK)
               sr_q[1] <= 1'b1;
            else begin
               busy <= 60;
               eop_q <= ers_q;
            end
         end else if (prg_q) begin
            arr[{addr[16], addr[4:0]}] <= dq_in;
            prg_q <= 1'b0;
         end else begin
            case (dq_in[7:0])
               8'hFF: stat_q <= 1'b0;
               8'h70: stat_q <= 1'b1;
               8'h50: sr_q <= sr_q & 8'hC5;
               8'hB0: sr_q <= {sr_q[7], busy > 0 && eop_q, sr_q[5:3], busy > 0 && !eop_q,
                  sr_q[1:0]};
               8'h40: begin
                  prg_q <= 1'b1;
                  stat_q <= 1'b1;
               end
               8'hD0: sr_q <= sr_q & 8'hBB;
               8'hE8, 8'hEA: begin
                  bst_q <= 2'h1;
                  blk_q <= addr[22:16];
                  stat_q <= 1'b1;
               end
               8'h20: begin
                  ers_q <= 1'b1;
                  stat_q <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// file: tb/pws_host_tb.sv
`timescale 1ns/1ps
`include "pws_map.vh"
module pws_host_tb;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg clk_en = 1'b1;
   reg [3:0] reg_addr = 4'h0;
   reg [31:0] reg_wdata = 32'h0;
   wire [31:0] reg_rdata_q;
   wire [22:0] mem_addr_q;
   wire [15:0] dq_out;
   wire [15:0] dev_dq;
   wire dq_oe, ce_n, oe_n, we_n;
   wire [15:0] dq_in = dq_oe ? dq_out : dev_dq;
   integer n_fail = 0;
   integer compares = 0;
   integer k, j, n;
   reg [15:0] wd [0:31];
   reg [31:0] got, r;
   reg [22:0] a;
   reg [4:0] cnt;
   pws_host uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .mem_addr_q(mem_addr_q), .mem_dq_in(dq_in), .mem_dq_out_q(dq_out), .mem_dq_oe_q(dq_oe),
      .mem_ce_n_q(ce_n), .mem_oe_n_q(oe_n), .mem_we_n_q(we_n));
   pws_dev_model dev (.clk(clk), .addr(mem_addr_q), .dq_in(dq_out), .dq_out(dev_dq),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
   initial begin
      forever #5 clk = ~clk;
   end
   function [9:0] exp_st(input lk, input es, input ws);
      exp_st = {lk, 1'b0, 1'b1, es, 3'h0, ws, lk, 1'b0};
   endfunction
   task tally_and_finish;
      begin
         $display("compares=%0d n_fail=%0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // one idle edge after each strobe keeps a driver from assigning twice in one step
   task wr(input [3:0] ad, input [31:0] d);
      begin
         reg_addr <= ad;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [3:0] ad);
      begin
         reg_addr <= ad;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 got = reg_rdata_q;
         @(posedge clk);
      end
   endtask
   task op(input [31:0] c);
      begin
         wr(`PWS_REG_CTRL, c);
         wait_idle;
      end
   endtask
   task wait_idle;
      begin
         n = 0;
         got = 32'h10;
         while (got[4] !== 1'b0 && n < 3000) begin
            rd(`PWS_REG_CTRL);
            n = n + 1;
         end
         if (n >= 3000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
         end
      end
   endtask
   initial begin
      r = $urandom(32'h80CA41FB);
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(`PWS_REG_STATUS);
      chk(got, 32'h0);
      rd(4'h9);
      chk(got, 32'h0);
      for (k = 0; k < 4; k = k + 1) begin
         r = $urandom;
         cnt = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : r[20:16];
         a = {7'h00, r[15:5], 5'h00};
         wr(`PWS_REG_ADDR, {9'h000, a});
         wr(`PWS_REG_COUNT, {27'h0, cnt});
         for (j = 0; j <= cnt; j = j + 1) begin
            r = $urandom;
            wd[j] = {r[15:4], 4'h5};
            wr(`PWS_REG_BUFWR, {16'h0, wd[j]});
         end
         op({27'h0, k[0], `PWS_OP_BUF_WRITE});
         rd(`PWS_REG_STATUS);
         chk(got[9:0], exp_st(1'b0, 1'b0, 1'b0));
         op({28'h0, `PWS_OP_READ_ARRAY});
         for (j = 0; j <= cnt; j = j + 1) begin
            wr(`PWS_REG_ADDR, {9'h000, a[22:5], j[4:0]});
            op({28'h0, `PWS_OP_READ});
            rd(`PWS_REG_RDATA);
            chk(got, {16'h0, wd[j]});
         end
      end
      wr(`PWS_REG_ADDR, 32'h0001_0000);
      op({28'h0, `PWS_OP_ERASE});
      rd(`PWS_REG_STATUS);
      chk(got[9:0], exp_st(1'b1, 1'b0, 1'b0));
      wr(`PWS_REG_ADDR, 32'h0000_0000);
      op({28'h0, `PWS_OP_ERASE});
      rd(`PWS_REG_STATUS);
      chk(got[9:0], exp_st(1'b1, 1'b0, 1'b0));
      op({28'h0, `PWS_OP_CLEAR});
      op({28'h0, `PWS_OP_SUSPEND});
      rd(`PWS_REG_STATUS);
      chk(got[9:0], exp_st(1'b0, 1'b0, 1'b0));
      op({28'h0, `PWS_OP_RESUME});
      wr(`PWS_REG_ADDR, 32'h0000_FFF0);
      wr(`PWS_REG_COUNT, 32'h1F);
      op({28'h0, `PWS_OP_BUF_WRITE});
      rd(`PWS_REG_CTRL);
      chk({31'h0, got[5]}, 32'h1);
      rd(`PWS_REG_STATUS);
      chk({24'h0, got[8:1]}, 32'h0000_00C0);
      // frozen clock enable: this write must not land
      clk_en <= 1'b0;
      wr(`PWS_REG_ADDR, 32'h0000_1234);
      clk_en <= 1'b1;
      rd(`PWS_REG_ADDR);
      chk(got, 32'h0000_FFF0);
      // suspend a buffered write into block 1 while it is still busy
      wr(`PWS_REG_ADDR, 32'h0001_0000);
      wr(`PWS_REG_COUNT, 32'h0);
      r = $urandom;
      wr(`PWS_REG_BUFWR, {16'h0, r[15:4], 4'h5});
      wr(`PWS_REG_CTRL, {28'h0, `PWS_OP_BUF_WRITE});
      wr(`PWS_REG_CTRL, {28'h0, `PWS_OP_SUSPEND});
      wait_idle;
      rd(`PWS_REG_STATUS);
      chk(got[9:0], exp_st(1'b0, 1'b0, 1'b1));
      op({28'h0, `PWS_OP_READ_ARRAY});
      wr(`PWS_REG_ADDR, {9'h000, a[22:5], 5'h00});
      op({28'h0, `PWS_OP_READ});
      rd(`PWS_REG_RDATA);
      chk(got, {16'h0, wd[0]});
      wr(`PWS_REG_ADDR, 32'h0001_0000);
      op({28'h0, `PWS_OP_RESUME});
      repeat (80) @(posedge clk);
      op({28'h0, `PWS_OP_READ});
      rd(`PWS_REG_RDATA);
      chk(got, {16'h0, r[15:4], 4'h5});
      // suspend an erase of block 0, program block 1 meanwhile
      wr(`PWS_REG_ADDR, 32'h0000_0000);
      wr(`PWS_REG_CTRL, {28'h0, `PWS_OP_ERASE});
      wr(`PWS_REG_CTRL, {28'h0, `PWS_OP_SUSPEND});
      wait_idle;
      rd(`PWS_REG_STATUS);
      chk(got[9:0], exp_st(1'b0, 1'b1, 1'b0));
      wr(`PWS_REG_ADDR, 32'h0001_0005);
      wr(`PWS_REG_DATA, {16'h0, r[31:20], 4'h5});
      op({28'h0, `PWS_OP_PROGRAM});
      op({28'h0, `PWS_OP_READ_ARRAY});
      op({28'h0, `PWS_OP_READ});
      rd(`PWS_REG_RDATA);
      chk(got, {16'h0, r[31:20], 4'h5});
      op({28'h0, `PWS_OP_RESUME});
      repeat (80) @(posedge clk);
      tally_and_finish;
   end
endmodule
